// File: sgr_pkg.sv
// package for the fabric global reset and interrupt registers
// assumes an apb slave with 32-bit data; register numbers are word indexes
package sgr_pkg;
  // register indexes (byte address = index * 4)
  localparam logic [11:0] SGR_IDX_IDENT   = 12'h000;
  localparam logic [11:0] SGR_IDX_RESET   = 12'h001;
  localparam logic [11:0] SGR_IDX_MASK    = 12'h004;
  localparam logic [11:0] SGR_IDX_PEND    = 12'h005;
  localparam logic [11:0] SGR_IDX_PORT0   = 12'h400;
  localparam logic [11:0] SGR_IDX_PORT1   = 12'h800;
  localparam logic [11:0] SGR_IDX_PORT2   = 12'hc00;
  localparam logic [11:0] SGR_IDX_SYSSTAT = 12'h010;
  localparam logic [11:0] SGR_IDX_SYSEN   = 12'h011;
  // fabric identity field positions
  localparam int SGR_ID_TYPE_LSB = 16;
  localparam int SGR_ID_VER_LSB  = 8;
  localparam int SGR_ID_REV_LSB  = 0;
  // port identity field positions
  localparam int SGR_PID_TYPE_LSB = 8;
  localparam int SGR_PID_VER_LSB  = 4;
  localparam int SGR_PID_REV_LSB  = 0;
  // mask / pending, reset and system status / enable bit positions
  localparam int SGR_BIT_BM    = 6;
  localparam int SGR_BIT_ENG   = 5;
  localparam int SGR_BIT_P2    = 2;
  localparam int SGR_BIT_P1    = 1;
  localparam int SGR_BIT_P0    = 0;
  localparam int SGR_BIT_RESET = 0;
  localparam int SGR_BIT_SWINT = 0;
  // valid bits and reset values
  localparam logic [8:0] SGR_MASK_RST   = 9'h1ff;
  localparam logic [8:0] SGR_MASK_RSVD  = 9'h198;
  localparam logic [6:0] SGR_PEND_VALID = 7'h67;
  localparam logic [6:0] SGR_PEND_RST   = 7'h00;
endpackage

// File: sgr_pend_bit.sv
// one read-clear pending bit: a set in the clearing cycle wins
// assumes set comes from same-clock logic
`timescale 1ns/1ps
module sgr_pend_bit
  import sgr_pkg::*;
(
  // clock and reset
  input  wire logic REF_CLK,
  input  wire logic RST_N,
  // control
  input  wire logic set_i,
  input  wire logic clr_i,
  // state
  output logic      pend_o
);
  typedef struct packed {
    logic pend_q;
  } sgrpb_s;
  sgrpb_s st_q;
  sgrpb_s st_d;

  always_comb begin
    st_d = st_q;
    if (clr_i) begin
      st_d.pend_q = 1'b0;
    end
    if (set_i) begin
      st_d.pend_q = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pend_o = st_q.pend_q;
endmodule

// File: sgr_sync.sv
// three-flop input synchroniser; output changes when stages two and three agree
// assumes input is asynchronous to REF_CLK
`timescale 1ns/1ps
module sgr_sync #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         REF_CLK,
  input  wire logic         RST_N,
  // data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
  } sgrsy_s;
  sgrsy_s st_q;
  sgrsy_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1_q = async_i;
    st_d.s2_q = st_q.s1_q;
    st_d.s3_q = st_q.s2_q;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2_q[i] == st_q.s3_q[i]) begin
        st_d.out_q[i] = st_q.s3_q[i];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.out_q;
endmodule

// File: sgr_csr.sv
// fabric identity, global reset, global irq mask and pending registers over apb
// assumes sub-block summaries are levels from outside the clock domain
`timescale 1ns/1ps
// Summary of operation
// RL1: fabric identity word holds type, version, revision
// RL2: writing one to reset bit asserts reset
// RL3: fabric reset drives every fabric block
// RL4: software clears the reset bit itself
// RL5: mask bit set masks, clear unmasks
// RL6: unmasked pending sets system fabric interrupt bit
// RL7: mask blocks interrupt, pending still updates
// RL8: software writes ones to reserved mask pairs
// RL9: mask bits 6,5,2,1,0 reset to one
// RL10: pending bit 6 follows buffer manager
// RL11: pending bit 5 follows switch engine
// RL12: pending bits 2..0 follow port macs
// RL13: pending read returns then clears bits
// RL14: three port register sets at port bases
// RL15: port identity holds type, version, revision
// RL16: read-only writes ignored, reserved reads zero (the reserved mask pairs read back as stored)
module sgr_csr
  import sgr_pkg::*;
#(
  parameter logic [7:0] FAB_TYPE  = 8'h11, // arbitrary value
  parameter logic [7:0] FAB_VER   = 8'h22, // arbitrary value
  parameter logic [7:0] FAB_REV   = 8'h33, // arbitrary value
  parameter logic [3:0] PORT_TYPE = 4'ha,  // arbitrary value
  parameter logic [3:0] PORT_VER  = 4'hb,  // arbitrary value
  parameter logic [3:0] PORT_REV  = 4'hc,  // arbitrary value
  parameter int         NBLK      = 4
) (
  // clock and reset
  input  wire logic            REF_CLK,
  input  wire logic            RST_N,
  // apb slave
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [13:0]     PADDR,
  input  wire logic [31:0]     PWDATA,
  input  wire logic [3:0]      PSTRB,
  output logic      [31:0]     PRDATA,
  output logic                 PREADY,
  output logic                 PSLVERR,
  // sub-block summaries (any unmasked bit of their own pending register)
  input  wire logic            BUFFER_MGR_SUMMARY,
  input  wire logic            ENGINE_SUMMARY,
  input  wire logic            PORT0_MAC_SUMMARY,
  input  wire logic            PORT1_MAC_SUMMARY,
  input  wire logic            PORT2_MAC_SUMMARY,
  // fabric reset to all blocks
  output logic [NBLK-1:0]      FABRIC_RESET,
  // system interrupt
  output logic                 SWITCH_IRQ
);
  // the apb answer, the registers other than pending, and the edge detector of the fabric
  // interrupt share one state word, so one clocked process registers all
  // of it; the answer phase is one-hot so an upset code falls back to idle
  typedef enum logic [1:0] {
    SGRCS_IDLE   = 2'b01,
    SGRCS_ANSWER = 2'b10
  } sgrcs_e;

  // one select line per decoded register
  typedef struct packed {
    logic ident;
    logic rst;
    logic mask;
    logic pend;
    logic sysstat;
    logic sysen;
    logic port;
  } sgrcs_sel_s;

  // all registered state of the block except the synchroniser and the pending bits
  typedef struct packed {
    sgrcs_e      state_q;
    logic        reset_q;
    logic [8:0]  mask_q;
    logic        sysstat_q;
    logic        sysen_q;
    logic        unm_q;
    logic [31:0] rdata_q;
    logic        err_q;
  } sgrcs_s;
  sgrcs_s st_q;
  sgrcs_s st_d;

  function automatic logic [31:0] fab_ident();
    logic [31:0] v;
    v = 32'h0;
    v[SGR_ID_TYPE_LSB +: 8] = FAB_TYPE;
    v[SGR_ID_VER_LSB +: 8]  = FAB_VER;
    v[SGR_ID_REV_LSB +: 8]  = FAB_REV;
    return v;
  endfunction

  function automatic logic [31:0] port_ident();
    logic [31:0] v;
    v = 32'h0;
    v[SGR_PID_TYPE_LSB +: 4] = PORT_TYPE;
    v[SGR_PID_VER_LSB +: 4]  = PORT_VER;
    v[SGR_PID_REV_LSB +: 4]  = PORT_REV;
    return v;
  endfunction

  // register decode, shared by the write and read paths
  function automatic sgrcs_sel_s decode_idx(logic [11:0] ix);
    sgrcs_sel_s s;
    s         = '0;
    s.ident   = (ix == SGR_IDX_IDENT);
    s.rst     = (ix == SGR_IDX_RESET);
    s.mask    = (ix == SGR_IDX_MASK);
    s.pend    = (ix == SGR_IDX_PEND);
    s.sysstat = (ix == SGR_IDX_SYSSTAT);
    s.sysen   = (ix == SGR_IDX_SYSEN);
    // the three port bases share one identity word
    s.port    = (ix == SGR_IDX_PORT0) || (ix == SGR_IDX_PORT1) ||
                (ix == SGR_IDX_PORT2); // RL14
    return s;
  endfunction

  // an index outside the map is refused with an error
  function automatic logic is_mapped(sgrcs_sel_s s);
    return s != '0;
  endfunction

  // low-lane strobe gates a single-bit register
  function automatic logic bit_write(logic old, logic [3:0] strb, logic wbit);
    logic v;
    v = old;
    if (strb[0]) begin
      v = wbit;
    end
    return v;
  endfunction

  // byte strobes gate the stored mask; reserved pairs are plain storage that
  // software keeps at ones, and they never gate a source
  function automatic logic [8:0] mask_write(logic [8:0] old, logic [31:0] wd,
                                            logic [3:0] strb);
    logic [8:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      v[8] = wd[8];
    end
    return v;
  endfunction

  // read word of a decoded register; write-only and reserved bits read zero, except the reserved mask pairs, which read back as stored
  function automatic logic [31:0] read_word(sgrcs_sel_s s, logic [8:0] msk,
                                            logic [6:0] pnd, logic sstat,
                                            logic sen);
    logic [31:0] v;
    v = 32'h0;
    if (s.ident) begin
      v = fab_ident(); // RL1
    end
    if (s.rst) begin
      v = 32'h0; // RL16
    end
    if (s.mask) begin
      v = {23'h0, msk};
    end
    if (s.pend) begin
      v = {25'h0, pnd}; // RL13
    end
    if (s.sysstat) begin
      v = {31'h0, sstat};
    end
    if (s.sysen) begin
      v = {31'h0, sen};
    end
    if (s.port) begin
      v = port_ident(); // RL15
    end
    return v;
  endfunction

  // system status bit: a rising unmasked pending sets it, a write of one
  // clears it, and a set in the clearing cycle wins
  function automatic logic sysstat_next(logic old, logic clr, logic rise);
    logic v;
    v = old;
    if (clr) begin
      v = 1'b0;
    end
    if (rise) begin
      v = 1'b1;
    end
    return v;
  endfunction

  // pending sources that may raise the fabric interrupt
  function automatic logic [6:0] pend_unmasked(logic [6:0] pnd, logic [8:0] msk);
    logic [6:0] v;
    v = pnd & ~msk[6:0] & SGR_PEND_VALID; // RL5 RL7
    return v;
  endfunction

  // synchronised summaries and pending bits
  logic [4:0]  summ_sync;
  logic [6:0]  pend;
  logic [6:0]  pend_set;
  logic        irq_unmasked;
  logic        irq_rise;

  // apb decode
  logic        access;
  logic        wr;
  logic        rd;
  logic        refuse;
  logic [11:0] idx;
  sgrcs_sel_s  sel;
  logic        mapped;

  // register strobes
  logic        pend_rd;
  logic        sys_clr;
  logic        we_reset;
  logic        we_mask;
  logic        we_sysen;

  sgr_sync #(
    .W(5)
  ) u_sync (
    .REF_CLK (REF_CLK),
    .RST_N   (RST_N),
    .async_i ({BUFFER_MGR_SUMMARY, ENGINE_SUMMARY, PORT2_MAC_SUMMARY,
               PORT1_MAC_SUMMARY, PORT0_MAC_SUMMARY}),
    .sync_o  (summ_sync)
  );

  // pending bits update regardless of mask
  always_comb begin
    pend_set = 7'h0;
    pend_set[SGR_BIT_BM]  = summ_sync[4]; // RL10 RL7
    pend_set[SGR_BIT_ENG] = summ_sync[3]; // RL11 RL7
    pend_set[SGR_BIT_P2]  = summ_sync[2]; // RL12
    pend_set[SGR_BIT_P1]  = summ_sync[1]; // RL12
    pend_set[SGR_BIT_P0]  = summ_sync[0]; // RL12
  end

  assign access   = PSEL && PENABLE && (st_q.state_q == SGRCS_IDLE);
  assign wr       = access && PWRITE;
  assign rd       = access && !PWRITE;
  assign refuse   = access && !mapped;
  assign idx      = PADDR[13:2];
  assign sel      = decode_idx(idx);
  assign mapped   = is_mapped(sel);
  // pending reads clear in the cycle that latches the answer
  assign pend_rd  = rd && sel.pend;
  // the single-bit registers sit in the low byte lane
  assign sys_clr  = wr && sel.sysstat && PSTRB[0] && PWDATA[SGR_BIT_SWINT];
  assign we_reset = wr && sel.rst;
  assign we_mask  = wr && sel.mask;
  assign we_sysen = wr && sel.sysen;

  for (genvar g = 0; g < 7; g++) begin : g_pend
    if (SGR_PEND_VALID[g]) begin : g_bit
      sgr_pend_bit u_bit (
        .REF_CLK (REF_CLK),
        .RST_N   (RST_N),
        .set_i   (pend_set[g]),
        .clr_i   (pend_rd), // RL13
        .pend_o  (pend[g])
      );
    end else begin : g_rsvd
      assign pend[g] = 1'b0;
    end
  end

  // mask set suppresses; reserved mask bits never gate a source
  assign irq_unmasked = |pend_unmasked(pend, st_q.mask_q); // RL5
  // pending bits keep updating under a set mask; only the event is gated
  assign irq_rise     = irq_unmasked && !st_q.unm_q;

  // next state: registers, answer and status in one place
  always_comb begin
    st_d           = st_q;
    st_d.err_q     = 1'b0;
    st_d.unm_q     = irq_unmasked;
    st_d.sysstat_q = sysstat_next(st_q.sysstat_q, sys_clr, irq_rise); // RL6
    // the answer stands for exactly one cycle after the taking edge
    unique case (st_q.state_q)
      SGRCS_IDLE: begin
        if (access) begin
          st_d.state_q = SGRCS_ANSWER;
        end
      end
      SGRCS_ANSWER: begin
        st_d.state_q = SGRCS_IDLE;
      end
      default: begin
        st_d.state_q = SGRCS_IDLE;
      end
    endcase
    // read data is zero whenever no answer is being prepared
    if (!access) begin
      st_d.rdata_q = 32'h0;
    end
    if (we_reset) begin
      st_d.reset_q = bit_write(st_q.reset_q, PSTRB, PWDATA[SGR_BIT_RESET]); // RL2
    end
    // the mask takes byte lanes 0 and 1
    if (we_mask) begin
      st_d.mask_q = mask_write(st_q.mask_q, PWDATA, PSTRB); // RL5
    end
    if (we_sysen) begin
      st_d.sysen_q = bit_write(st_q.sysen_q, PSTRB, PWDATA[SGR_BIT_SWINT]);
    end
    // identity, pending and port identity take no write
    // a pending read returns the bits set before this edge
    if (rd) begin
      st_d.rdata_q = read_word(sel, st_q.mask_q, pend, st_q.sysstat_q, st_q.sysen_q);
    end
    if (refuse) begin
      st_d.rdata_q = 32'h0; // RL16
      st_d.err_q   = 1'b1;
    end
  end

  // asynchronous reset loads constants only
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '{state_q:   SGRCS_IDLE,
                reset_q:   1'b0,
                mask_q:    SGR_MASK_RST, // RL9
                sysstat_q: 1'b0,
                sysen_q:   1'b0,
                unm_q:     1'b0,
                rdata_q:   32'h0,
                err_q:     1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // handshake decoded from the state flop; data outputs straight from flops
  assign PREADY       = (st_q.state_q == SGRCS_ANSWER);
  assign PRDATA       = st_q.rdata_q;
  assign PSLVERR      = st_q.err_q;
  assign FABRIC_RESET = {NBLK{st_q.reset_q}}; // RL3
  assign SWITCH_IRQ   = st_q.sysstat_q && st_q.sysen_q;
endmodule

// File: sgr_csr_asserts.sv
// assertions on the apb answer and fabric reset of sgr_csr
// assumes it is bound into sgr_csr
`timescale 1ns/1ps
module sgr_csr_asserts
  import sgr_pkg::*;
#(
  parameter int NBLK = 4
) (
  // clock and reset
  input wire logic            REF_CLK,
  input wire logic            RST_N,
  // apb
  input wire logic            PSEL,
  input wire logic            PENABLE,
  input wire logic            PWRITE,
  input wire logic [13:0]     PADDR,
  input wire logic [31:0]     PWDATA,
  input wire logic [3:0]      PSTRB,
  input wire logic [31:0]     PRDATA,
  input wire logic            PREADY,
  input wire logic            PSLVERR,
  // fabric reset
  input wire logic [NBLK-1:0] FABRIC_RESET
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  wire        tk = PSEL && PENABLE && !PREADY;
  wire [11:0] ix = PADDR[13:2];
  wire        rd = tk && !PWRITE;
  wire        wr = tk && PWRITE && ix == SGR_IDX_RESET && PSTRB[0];
  wire        mp = ix inside {12'h000, 12'h001, 12'h004, 12'h005, 12'h010, 12'h011,
                              12'h400, 12'h800, 12'hc00};
  a_ready_next: assert property (tk |=> PREADY)
    else $error("no ready after access");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (tk && !mp |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_reset_copies: assert property (FABRIC_RESET == '0 || FABRIC_RESET == '1)
    else $error("fabric reset copies differ");
  a_reset_set: assert property (wr && PWDATA[0] |-> ##[1:3] &FABRIC_RESET)
    else $error("fabric reset not asserted");
  a_reset_clear: assert property (wr && !PWDATA[0] |-> ##[1:3] !(|FABRIC_RESET))
    else $error("fabric reset not released");
  a_ident_rsvd: assert property (rd && ix == SGR_IDX_IDENT |=> PRDATA[31:24] == 8'h0)
    else $error("identity reserved bits set");
  a_port_rsvd: assert property (rd && ix[9:0] == 10'h0 && ix[11:10] != 2'h0
    |=> PRDATA[31:12] == 20'h0)
    else $error("port identity reserved bits set");
  a_pend_rsvd: assert property (rd && ix == SGR_IDX_PEND
    |=> PRDATA[31:7] == 25'h0 && PRDATA[4:3] == 2'h0)
    else $error("pending reserved bits set");
endmodule

// File: switch_global_reset_irq_csrs_test.sv
// self-checking bench for sgr_csr
// assumes sgr_pkg, sgr_csr and sgr_csr_asserts are compiled first
`timescale 1ns/1ps
module switch_global_reset_irq_csrs_test
  import sgr_pkg::*;
;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        pen = 0;
  logic        pwr = 0;
  logic        rdy;
  logic        err;
  logic        irq;
  logic        serr;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [3:0]  pstrb = 4'hf;
  logic [4:0]  summ = '0;
  logic [3:0]  frst;
  logic [11:0] a;
  logic [15:0] lf = 16'h13;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  sgr_csr DUT (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(rdy),
    .PSLVERR(err), .BUFFER_MGR_SUMMARY(summ[4]), .ENGINE_SUMMARY(summ[3]),
    .PORT0_MAC_SUMMARY(summ[0]), .PORT1_MAC_SUMMARY(summ[1]),
    .PORT2_MAC_SUMMARY(summ[2]), .FABRIC_RESET(frst), .SWITCH_IRQ(irq));
  always #5 clk = ~clk;
  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // pending bit of summary input s: ports 0..2, then engine, buffer manager
  function automatic logic [31:0] exp_pend(int s);
    return 32'h1 << (s > 2 ? s + 2 : s);
  endfunction
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [11:0] ix, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {ix, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50)
      errors++;
    rd = prdata;
    serr = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, SGR_IDX_MASK, 0);
    chk("mask rst", rd, 32'h1ff);
    apb(0, SGR_IDX_PEND, 0);
    chk("pend rst", rd, 0);
    apb(0, SGR_IDX_RESET, 0);
    chk("reset rd", rd, 0);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? SGR_IDX_IDENT : 12'(i << 10);
      apb(1, a, {lf, lf});
      apb(0, a, 0);
      chk("ident", rd, i == 0 ? 32'h00112233 : 32'h00000abc);
      lf = nxt(lf);
    end
    apb(0, 12'h002, 0);
    chk("unmapped err", serr, 1);
    apb(1, SGR_IDX_RESET, 1);
    repeat (24) @(posedge clk);
    chk("frst set", frst, 32'hf);
    apb(1, SGR_IDX_RESET, 0);
    repeat (4) @(posedge clk);
    chk("frst clr", frst, 0);
    apb(1, SGR_IDX_MASK, lf | 32'h198);
    apb(0, SGR_IDX_MASK, 0);
    chk("mask rw", rd, (lf | 32'h198) & 32'h1ff);
    pstrb <= 4'h1;
    apb(1, SGR_IDX_MASK, 32'h098);
    pstrb <= 4'hf;
    apb(0, SGR_IDX_MASK, 0);
    chk("mask strb", rd, 32'h198);
    apb(1, 12'h003, 32'hffffffff);
    chk("unmapped wr", serr, 1);
    apb(1, SGR_IDX_SYSEN, 1);
    for (int s = 0; s < 5; s++) begin
      for (int m = 1; m >= 0; m--) begin
        apb(1, SGR_IDX_MASK, m ? 32'h1ff : 32'h1ff & ~exp_pend(s));
        summ[s] <= 1'b1;
        repeat (8 + lf[2:0]) @(posedge clk);
        summ[s] <= 1'b0;
        lf = nxt(lf);
        repeat (8) @(posedge clk);
        chk("irq", irq, m ? 0 : 1);
        apb(0, SGR_IDX_PEND, 0);
        chk("pend", rd, exp_pend(s));
        apb(0, SGR_IDX_PEND, 0);
        chk("pend clr", rd, 0);
        apb(1, SGR_IDX_SYSSTAT, 1);
        repeat (2) @(posedge clk);
        chk("irq clr", irq, 0);
      end
    end
    results();
  end
endmodule
bind sgr_csr sgr_csr_asserts #(.NBLK(NBLK)) u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FABRIC_RESET(FABRIC_RESET));
